// [hdl/ppsd_pkg.sv]
package ppsd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned SD_HOLD_NS = 1200;
    localparam int unsigned SD_HOLD_CYC = SD_HOLD_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam logic [7:0] SD_HOLD_LAST = 8'(SD_HOLD_CYC - 1);
    localparam logic [7:0] QUIET_MAX = 8'hff;
    localparam logic [1:0] SD_PULSE_LAST = 2'h1;
    localparam logic [2:0] SYM_LAST = 3'h4;
    localparam logic [2:0] TXC_HI_LAST = 3'h1;
    localparam logic [2:0] RXC_HI_FIRST = 3'h2;
    localparam logic [2:0] RXC_HI_LAST = 3'h3;
    localparam logic [4:0] REF_TIMEOUT = 5'h10;
    localparam logic [6:0] LOCK_MATCHES = 7'h3c;

    ////////////////////////////////////////////////////////////////////////////
    // Scrambler sequence.
    localparam int unsigned LFSR_W = 11;
    localparam int unsigned TAP_HI = 10;
    localparam int unsigned TAP_LO = 8;
    localparam logic [10:0] LFSR_SEED = 11'h7ff;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: index times four is the byte address.
    localparam logic [7:0] IDX_BASIC = 8'h00;
    localparam logic [7:0] IDX_VENDOR = 8'h10;
    localparam logic [7:0] IDX_STATUS = 8'h1f;
    localparam logic [7:0] ADDR_BASIC = IDX_BASIC * 8'h04;
    localparam logic [7:0] ADDR_VENDOR = IDX_VENDOR * 8'h04;
    localparam logic [7:0] ADDR_STATUS = IDX_STATUS * 8'h04;
    localparam int unsigned BIT_CHIP_POWERDOWN_BIT = 11;
    localparam int unsigned BIT_SPEED = 13;
    localparam int unsigned BIT_RXPS = 0;
    localparam int unsigned BIT_TXHIZ = 12;
    localparam int unsigned BIT_ST_SD = 0;
    localparam int unsigned BIT_ST_LOCK = 1;
    localparam int unsigned BIT_ST_REF = 2;
    localparam int unsigned BIT_ST_FRAME = 3;
    localparam logic RST_CHIP_POWERDOWN_BIT = 1'b0;
    localparam logic RST_SPEED = 1'b1;
    localparam logic RST_RXPS = 1'b0;
    localparam logic RST_TXHIZ = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Synchroniser lanes.
    localparam int unsigned SY_NRZI = 0;
    localparam int unsigned SY_PULSE = 1;
    localparam int unsigned SY_MANCH = 2;
    localparam int unsigned SY_PRE = 3;
    localparam int unsigned SY_REF = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Code groups, sent leftmost bit first.
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0d;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [4:0] CG_H = 5'h04;
    localparam logic [3:0] NIB_PRE = 4'h5;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_K = 2'b01,
        TX_DATA = 2'b10,
        TX_R = 2'b11
    } ppsd_tx_e;

    // Maps a data nibble to its code group.
    function automatic logic [4:0] enc4b5b(input logic [3:0] n);
        logic [4:0] c;
        c = 5'h1e;
        case (n)
            4'h0: c = 5'h1e;
            4'h1: c = 5'h09;
            4'h2: c = 5'h14;
            4'h3: c = 5'h15;
            4'h4: c = 5'h0a;
            4'h5: c = 5'h0b;
            4'h6: c = 5'h0e;
            4'h7: c = 5'h0f;
            4'h8: c = 5'h12;
            4'h9: c = 5'h13;
            4'ha: c = 5'h16;
            4'hb: c = 5'h17;
            4'hc: c = 5'h1a;
            4'hd: c = 5'h1b;
            4'he: c = 5'h1c;
            default: c = 5'h1d;
        endcase
        return c;
    endfunction

    // Maps a code group back; bit 4 of the result is high for a data group.
    function automatic logic [4:0] dec5b4b(input logic [4:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (enc4b5b(4'(i)) == c) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

endpackage

// [hdl/ppsd_lfsr.sv]
`timescale 1ns/100ps
module ppsd_lfsr (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic load,
    input wire logic load_bit,
    output logic key
);
    typedef struct packed {
        logic [ppsd_pkg::LFSR_W-1:0] sr;
    } ppsd_lfsr_s;

    ppsd_lfsr_s st_r;
    ppsd_lfsr_s st_nxt;

    // Key bit of the eleven-bit sequence x^11 + x^9 + 1.
    assign key = st_r.sr[ppsd_pkg::TAP_HI] ^ st_r.sr[ppsd_pkg::TAP_LO];

    // Each step shifts in the key, or an observed key bit while synchronising.
    always_comb begin
        st_nxt = st_r;
        if (step) begin
            st_nxt.sr = {st_r.sr[ppsd_pkg::LFSR_W-2:0], load ? load_bit : key};
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r.sr <= ppsd_pkg::LFSR_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// [hdl/ppsd_phy_core.sv]
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// R1 - Power-down bit shuts all circuitry off; register access keeps working.
// R2 - Receive power-save powers receive circuits down without signal, up on detect; the code does so only in 100 Mb/s mode.
// R3 - Receive power-save stops receive clock while idle; only in 100 Mb/s mode.
// R4 - Transmit high-impedance floats line drivers and transmit clock with pull-up.
// R5 - Transmit high-impedance bit resets to zero; only reset clears it. The code also clears it on a register write of zero.
// R6 - Transmit serial clock is reference times five, or four fifths at 10 Mb/s.
// R7 - Signal detect after two valid pulses; threshold lowered, adaptive loops released.
// R8 - Detect drops after 1.2 us quiet at 100, without Manchester at 10.
// R9 - Recovery loop follows transmit clock until detect, then the line; the code switches to the line only in 100 Mb/s mode.
// R10 - At 10 Mb/s, preamble detection realigns the recovered clock phase at once.
// R11 - Transmit nibbles become code groups, are scrambled and serialised.
// R12 - Receive stream descrambled, aligned on start delimiter, decoded to nibbles.
// R13 - Received NRZI bits retimed, converted to NRZ before deserialising.
// R14 - Eleven-bit scrambler sequence; descrambler synchronises on idle code groups.
module ppsd_phy_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic reference_clock_in_pin,
    input wire logic [3:0] mii_txd,
    input wire logic mii_tx_en,
    input wire logic mii_tx_er,
    output logic mii_tx_clk_o,
    output logic mii_tx_clk_oe_n,
    output logic mii_tx_clk_pullup_en,
    output logic mii_rx_clk,
    output logic [3:0] mii_rxd,
    output logic mii_rx_dv,
    output logic mii_rx_er,
    output logic line_tx_nrzi,
    output logic line_drv_oe_n,
    input wire logic line_rx_nrzi,
    input wire logic line_rx_pulse,
    input wire logic line_manchester_present,
    input wire logic line_preamble_seen,
    output logic core_power_on,
    output logic rx_circuit_power_on,
    output logic synth_mult_x5,
    output logic signal_detect,
    output logic sd_threshold_low,
    output logic adapt_release,
    output logic cdr_ref_from_line,
    output logic cdr_phase_realign
);
    typedef struct packed {
        logic chip_powerdown_bit;
        logic speed;
        logic rxps;
        logic txhiz;
        logic [15:0] rdata;
        logic [4:0] s1;
        logic [4:0] s2;
        logic ref_prev;
        logic pulse_prev;
        logic pre_prev;
        logic nrzi_prev;
        logic [4:0] ref_cnt;
        logic ref_alive;
        logic [1:0] pulse_cnt;
        logic sd;
        logic [7:0] sd_cnt;
        logic [7:0] quiet;
        logic realign;
        logic [2:0] tx_cnt;
        ppsd_pkg::ppsd_tx_e tx_st;
        logic [4:0] tx_grp;
        logic tx_line;
        logic tx_clk;
        logic [2:0] rx_cnt;
        logic [9:0] rx_sh;
        logic rx_lock;
        logic [6:0] lock_cnt;
        logic rx_frame;
        logic [3:0] rxd;
        logic rx_dv;
        logic rx_er;
        logic rx_clk;
    } ppsd_core_s;

    ppsd_core_s st_r;
    ppsd_core_s st_nxt;
    logic ref_edge;
    logic pulse_edge;
    logic pre_edge;
    logic tx_run;
    logic rx_pwr;
    logic rx_on;
    logic nrz;
    logic plain;
    logic tx_key;
    logic rx_key;
    logic [4:0] grp;
    logic [4:0] dec;

    ////////////////////////////////////////////////////////////////////////////
    // Edges of synchronised pins and operating conditions.
    assign ref_edge = st_r.s2[ppsd_pkg::SY_REF] & ~st_r.ref_prev;
    assign pulse_edge = st_r.s2[ppsd_pkg::SY_PULSE] & ~st_r.pulse_prev;
    assign pre_edge = st_r.s2[ppsd_pkg::SY_PRE] & ~st_r.pre_prev;
    assign tx_run = ~st_r.chip_powerdown_bit & st_r.speed & st_r.ref_alive;
    assign rx_pwr = ~st_r.chip_powerdown_bit & ~(st_r.rxps & st_r.speed & ~st_r.sd); // R2 R3
    assign rx_on = ~st_r.chip_powerdown_bit & st_r.speed & st_r.sd;
    assign nrz = st_r.s2[ppsd_pkg::SY_NRZI] ^ st_r.nrzi_prev; // R13
    assign plain = nrz ^ rx_key;

    // Transmit scrambler and receive descrambler.
    ppsd_lfsr u_scr (
        .clk(clk),
        .rst_n(rst_n),
        .step(tx_run),
        .load(1'b0),
        .load_bit(1'b0),
        .key(tx_key)
    );

    ppsd_lfsr u_descr (
        .clk(clk),
        .rst_n(rst_n),
        .step(rx_on),
        .load(~st_r.rx_lock),
        .load_bit(~nrz),
        .key(rx_key)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        grp = ppsd_pkg::CG_IDLE;
        dec = 5'h00;
        st_nxt = st_r;
        // Register writes and reads stay alive in power-down.
        st_nxt.rdata = 16'h0000;
        if (reg_wr && reg_addr == ppsd_pkg::ADDR_BASIC) begin // R1
            st_nxt.chip_powerdown_bit = reg_wdata[ppsd_pkg::BIT_CHIP_POWERDOWN_BIT];
            st_nxt.speed = reg_wdata[ppsd_pkg::BIT_SPEED];
        end
        if (reg_wr && reg_addr == ppsd_pkg::ADDR_VENDOR) begin
            st_nxt.rxps = reg_wdata[ppsd_pkg::BIT_RXPS];
            st_nxt.txhiz = reg_wdata[ppsd_pkg::BIT_TXHIZ];
        end
        if (reg_rd) begin
            case (reg_addr)
                ppsd_pkg::ADDR_BASIC: begin
                    st_nxt.rdata[ppsd_pkg::BIT_CHIP_POWERDOWN_BIT] = st_r.chip_powerdown_bit;
                    st_nxt.rdata[ppsd_pkg::BIT_SPEED] = st_r.speed;
                end
                ppsd_pkg::ADDR_VENDOR: begin
                    st_nxt.rdata[ppsd_pkg::BIT_RXPS] = st_r.rxps;
                    st_nxt.rdata[ppsd_pkg::BIT_TXHIZ] = st_r.txhiz;
                end
                ppsd_pkg::ADDR_STATUS: begin
                    st_nxt.rdata[ppsd_pkg::BIT_ST_SD] = st_r.sd;
                    st_nxt.rdata[ppsd_pkg::BIT_ST_LOCK] = st_r.rx_lock;
                    st_nxt.rdata[ppsd_pkg::BIT_ST_REF] = st_r.ref_alive;
                    st_nxt.rdata[ppsd_pkg::BIT_ST_FRAME] = st_r.rx_frame;
                end
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        // Two-stage synchronisers and edge history.
        st_nxt.s1 = {reference_clock_in_pin, line_preamble_seen, line_manchester_present,
                     line_rx_pulse, line_rx_nrzi};
        st_nxt.s2 = st_r.s1;
        st_nxt.ref_prev = st_r.s2[ppsd_pkg::SY_REF];
        st_nxt.pulse_prev = st_r.s2[ppsd_pkg::SY_PULSE];
        st_nxt.pre_prev = st_r.s2[ppsd_pkg::SY_PRE];
        st_nxt.nrzi_prev = st_r.s2[ppsd_pkg::SY_NRZI];
        // The synthesiser runs only while reference edges keep arriving.
        if (ref_edge) begin
            st_nxt.ref_cnt = 5'h00;
            st_nxt.ref_alive = 1'b1;
        end else if (st_r.ref_cnt == ppsd_pkg::REF_TIMEOUT) begin
            st_nxt.ref_alive = 1'b0;
        end else begin
            st_nxt.ref_cnt = st_r.ref_cnt + 5'h01;
        end
        st_nxt.quiet = pulse_edge ? 8'h00 : (st_r.quiet == ppsd_pkg::QUIET_MAX) ? st_r.quiet : st_r.quiet + 8'h01;
        // Signal qualification; a power-down write clears detect at the same edge.
        if (st_nxt.chip_powerdown_bit) begin
            st_nxt.sd = 1'b0;
            st_nxt.pulse_cnt = 2'h0;
        end else if (!st_r.sd) begin
            if (pulse_edge && st_r.pulse_cnt == ppsd_pkg::SD_PULSE_LAST) begin // R7
                st_nxt.sd = 1'b1;
                st_nxt.sd_cnt = 8'h00;
            end else if (pulse_edge) begin
                st_nxt.pulse_cnt = st_r.pulse_cnt + 2'h1;
            end
        end else if (!st_r.speed) begin
            if (!st_r.s2[ppsd_pkg::SY_MANCH]) begin // R8
                st_nxt.sd = 1'b0;
                st_nxt.pulse_cnt = 2'h0;
            end
        end else if (pulse_edge) begin
            st_nxt.sd_cnt = 8'h00;
        end else if (st_r.sd_cnt == ppsd_pkg::SD_HOLD_LAST) begin // R8
            st_nxt.sd = 1'b0;
            st_nxt.pulse_cnt = 2'h0;
        end else begin
            st_nxt.sd_cnt = st_r.sd_cnt + 8'h01;
        end
        st_nxt.realign = ~st_r.chip_powerdown_bit & ~st_r.speed & pre_edge; // R10
        // Transmit: one code bit per cycle, five per nibble.
        if (!tx_run) begin
            st_nxt.tx_cnt = 3'h0;
            st_nxt.tx_st = ppsd_pkg::TX_IDLE;
            st_nxt.tx_grp = ppsd_pkg::CG_IDLE;
            st_nxt.tx_clk = 1'b0;
        end else begin
            if (st_r.tx_grp[4] ^ tx_key) begin // R11
                st_nxt.tx_line = ~st_r.tx_line;
            end
            if (st_r.tx_cnt == ppsd_pkg::SYM_LAST) begin // R6
                st_nxt.tx_cnt = 3'h0;
                case (st_r.tx_st)
                    ppsd_pkg::TX_IDLE: begin
                        grp = mii_tx_en ? ppsd_pkg::CG_J : ppsd_pkg::CG_IDLE;
                        st_nxt.tx_st = mii_tx_en ? ppsd_pkg::TX_K : ppsd_pkg::TX_IDLE;
                    end
                    ppsd_pkg::TX_K: begin
                        grp = ppsd_pkg::CG_K;
                        st_nxt.tx_st = ppsd_pkg::TX_DATA;
                    end
                    ppsd_pkg::TX_DATA: begin
                        if (!mii_tx_en) begin
                            grp = ppsd_pkg::CG_T;
                            st_nxt.tx_st = ppsd_pkg::TX_R;
                        end else begin
                            grp = mii_tx_er ? ppsd_pkg::CG_H : ppsd_pkg::enc4b5b(mii_txd); // R11
                        end
                    end
                    ppsd_pkg::TX_R: begin
                        grp = ppsd_pkg::CG_R;
                        st_nxt.tx_st = ppsd_pkg::TX_IDLE;
                    end
                    default: st_nxt.tx_st = ppsd_pkg::TX_IDLE;
                endcase
                st_nxt.tx_grp = grp;
            end else begin
                st_nxt.tx_cnt = st_r.tx_cnt + 3'h1;
                st_nxt.tx_grp = {st_r.tx_grp[3:0], 1'b0};
            end
            st_nxt.tx_clk = st_nxt.tx_cnt <= ppsd_pkg::TXC_HI_LAST;
        end
        // Receive clock divider stops while receive circuits sleep.
        if (!rx_pwr) begin // R3
            st_nxt.rx_cnt = 3'h0;
        end else begin
            st_nxt.rx_cnt = (st_r.rx_cnt == ppsd_pkg::SYM_LAST) ? 3'h0 : st_r.rx_cnt + 3'h1;
        end
        // Receive datapath: descrambler lock, alignment and decoding.
        if (!rx_on) begin
            st_nxt.rx_lock = 1'b0;
            st_nxt.lock_cnt = 7'h00;
            st_nxt.rx_frame = 1'b0;
            st_nxt.rx_dv = 1'b0;
            st_nxt.rx_er = 1'b0;
        end else begin
            if (!st_r.rx_lock) begin // R14
                if (~nrz == rx_key) begin
                    st_nxt.lock_cnt = st_r.lock_cnt + 7'h01;
                    st_nxt.rx_lock = st_r.lock_cnt == ppsd_pkg::LOCK_MATCHES;
                end else begin
                    st_nxt.lock_cnt = 7'h00;
                end
            end
            st_nxt.rx_sh = {st_r.rx_sh[8:0], plain};
            if (!st_r.rx_frame) begin
                if (st_r.rx_cnt == ppsd_pkg::SYM_LAST) begin
                    st_nxt.rx_er = 1'b0;
                end
                if (st_r.rx_lock && {st_r.rx_sh[8:0], plain} == {ppsd_pkg::CG_J, ppsd_pkg::CG_K}) begin // R12
                    st_nxt.rx_frame = 1'b1;
                    st_nxt.rx_cnt = 3'h0;
                    st_nxt.rxd = ppsd_pkg::NIB_PRE;
                    st_nxt.rx_dv = 1'b1;
                    st_nxt.rx_er = 1'b0;
                end
            end else if (st_r.rx_cnt == ppsd_pkg::SYM_LAST) begin
                grp = {st_r.rx_sh[3:0], plain};
                dec = ppsd_pkg::dec5b4b(grp);
                if (grp == ppsd_pkg::CG_T || grp == ppsd_pkg::CG_IDLE) begin
                    st_nxt.rx_frame = 1'b0;
                    st_nxt.rx_dv = 1'b0;
                    st_nxt.rx_er = grp == ppsd_pkg::CG_IDLE;
                end else begin // R12
                    st_nxt.rxd = dec[3:0];
                    st_nxt.rx_er = ~dec[4];
                end
            end
        end
        st_nxt.rx_clk = rx_pwr && st_nxt.rx_cnt >= ppsd_pkg::RXC_HI_FIRST && st_nxt.rx_cnt <= ppsd_pkg::RXC_HI_LAST;
    end

    // State register; reset clears the high-impedance bit among the rest.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.speed <= ppsd_pkg::RST_SPEED;
            st_r.chip_powerdown_bit <= ppsd_pkg::RST_CHIP_POWERDOWN_BIT;
            st_r.rxps <= ppsd_pkg::RST_RXPS;
            st_r.txhiz <= ppsd_pkg::RST_TXHIZ; // R5
            st_r.tx_grp <= ppsd_pkg::CG_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign reg_rdata = st_r.rdata;
    assign mii_tx_clk_o = st_r.tx_clk;
    assign mii_tx_clk_oe_n = st_r.txhiz | st_r.chip_powerdown_bit; // R4
    assign mii_tx_clk_pullup_en = st_r.txhiz; // R4
    assign line_drv_oe_n = st_r.txhiz | ~tx_run; // R4
    assign line_tx_nrzi = st_r.tx_line;
    assign mii_rx_clk = st_r.rx_clk;
    assign mii_rxd = st_r.rxd;
    assign mii_rx_dv = st_r.rx_dv;
    assign mii_rx_er = st_r.rx_er;
    assign core_power_on = ~st_r.chip_powerdown_bit; // R1
    assign rx_circuit_power_on = rx_pwr;
    assign synth_mult_x5 = st_r.speed; // R6
    assign signal_detect = st_r.sd;
    assign sd_threshold_low = st_r.sd; // R7
    assign adapt_release = st_r.sd; // R7
    assign cdr_ref_from_line = st_r.sd & st_r.speed; // R9
    assign cdr_phase_realign = st_r.realign;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_tx_j;
        st_r.tx_st == ppsd_pkg::TX_IDLE && st_nxt.tx_st == ppsd_pkg::TX_K;
    endsequence
    sequence s_tx_k;
        st_r.tx_grp == ppsd_pkg::CG_K && st_r.tx_st == ppsd_pkg::TX_DATA;
    endsequence

    property p_chip_powerdown_bit;
        st_r.chip_powerdown_bit |-> !rx_circuit_power_on && !core_power_on && line_drv_oe_n && !signal_detect;
    endproperty
    a_chip_powerdown_bit: assert property (p_chip_powerdown_bit) else $error("power-down left circuits on"); // R1

    property p_rxps;
        st_r.rxps && st_r.speed && !st_r.sd [*2] |-> !mii_rx_clk && !rx_circuit_power_on;
    endproperty
    a_rxps: assert property (p_rxps) else $error("receive clock ran while idle"); // R3

    property p_txhiz;
        st_r.txhiz |-> mii_tx_clk_oe_n && line_drv_oe_n && mii_tx_clk_pullup_en;
    endproperty
    a_txhiz: assert property (p_txhiz) else $error("transmit outputs not floated"); // R4

    property p_txhiz_rst;
        $rose(rst_n) |-> !st_r.txhiz && !mii_tx_clk_pullup_en;
    endproperty
    a_txhiz_rst: assert property (p_txhiz_rst) else $error("high-impedance bit not reset"); // R5

    property p_sd_two;
        $rose(signal_detect) |-> $past(pulse_edge) && sd_threshold_low && adapt_release;
    endproperty
    a_sd_two: assert property (p_sd_two) else $error("detect rose without pulses"); // R7

    property p_sd_hold;
        signal_detect && st_r.speed && $past(st_r.speed) |-> st_r.quiet < 8'(ppsd_pkg::SD_HOLD_CYC);
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("detect held past quiet time"); // R8

    property p_cdr;
        !signal_detect |-> !cdr_ref_from_line;
    endproperty
    a_cdr: assert property (p_cdr) else $error("recovery loop on line without detect"); // R9

    property p_realign;
        !st_r.chip_powerdown_bit && !st_r.speed && pre_edge |=> cdr_phase_realign;
    endproperty
    a_realign: assert property (p_realign) else $error("preamble did not realign"); // R10

    property p_tx_jk;
        s_tx_j ##1 tx_run [*5] |=> s_tx_k;
    endproperty
    a_tx_jk: assert property (p_tx_jk) else $error("start delimiter broken"); // R11

    property p_rx_start;
        $rose(mii_rx_dv) |-> mii_rxd == ppsd_pkg::NIB_PRE && st_r.rx_lock && st_r.rx_cnt == 3'h0;
    endproperty
    a_rx_start: assert property (p_rx_start) else $error("receive frame began badly"); // R12
endmodule

// [test/ppsd_mac_model.sv]
`timescale 1ns/100ps
// Transmit half of the MAC: hands over one queued nibble per transmit clock.
module ppsd_mac_model (
    input wire logic clk,
    input wire logic tx_clk,
    output logic [3:0] txd,
    output logic tx_en,
    output logic tx_er
);
    logic [3:0] nib_q[$];
    logic clk_q = 1'b0;
    initial begin
        txd = 4'h0;
        tx_en = 1'b0;
        tx_er = 1'b0;
    end
    // Changes just after the transmit clock rises; idle data toggles so stale values never look valid.
    always @(posedge clk) begin
        clk_q <= tx_clk;
        if (tx_clk && !clk_q) begin
            tx_en <= (nib_q.size() != 0);
            txd <= (nib_q.size() != 0) ? nib_q.pop_front() : ~txd;
        end
    end
endmodule

// [test/phy_pcs_power_signal_detect_test.sv]
`timescale 1ns/100ps
module phy_pcs_power_signal_detect_test;
    logic clk = 1'b0, rst_n = 1'b0, ref_clk = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic [3:0] txd, rxd, nib, pulse_cnt = 4'h0;
    logic tx_en, tx_er, tx_clk, tx_oe_n, tx_pu, rx_clk, rx_dv, rx_er, tx_nrzi, drv_oe_n, seen;
    logic rx_nrzi = 1'b0, manch = 1'b0, pre = 1'b0, pulse_run = 1'b0, rxc_q = 1'b0;
    logic pwr, rx_pwr, x5, sd, thr, adapt, cdr_line, realign;
    logic [4:0] exp_q[$];
    int failures = 0, tests_run = 0, cycles = 0, seed = 32'h37d23ad1;

    always #4 clk = ~clk;
    always #32 ref_clk = ~ref_clk;

    // Line pulses rise every eight cycles while running; the line output is looped back.
    always @(posedge clk) begin
        pulse_cnt <= pulse_run ? pulse_cnt + 4'h1 : 4'h0;
        rx_nrzi <= tx_nrzi;
    end

    ppsd_phy_core ppsd_phy_core_i (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_clock_in_pin(ref_clk),
        .mii_txd(txd), .mii_tx_en(tx_en), .mii_tx_er(tx_er), .mii_tx_clk_o(tx_clk),
        .mii_tx_clk_oe_n(tx_oe_n), .mii_tx_clk_pullup_en(tx_pu), .mii_rx_clk(rx_clk),
        .mii_rxd(rxd), .mii_rx_dv(rx_dv), .mii_rx_er(rx_er), .line_tx_nrzi(tx_nrzi),
        .line_drv_oe_n(drv_oe_n), .line_rx_nrzi(rx_nrzi), .line_rx_pulse(pulse_run & pulse_cnt[2]),
        .line_manchester_present(manch), .line_preamble_seen(pre), .core_power_on(pwr),
        .rx_circuit_power_on(rx_pwr), .synth_mult_x5(x5), .signal_detect(sd), .sd_threshold_low(thr),
        .adapt_release(adapt), .cdr_ref_from_line(cdr_line), .cdr_phase_realign(realign)
    );

    ppsd_mac_model ppsd_mac_model_i (.clk(clk), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", exp, reg_rdata);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulses(input int n);
        @(posedge clk);
        pulse_run <= 1'b1;
        repeat (n) @(posedge clk);
        pulse_run <= 1'b0;
    endtask

    task automatic finish_test;
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Takes the oldest expected nibble whenever the receive clock rises inside a frame.
    always @(negedge clk) begin
        rxc_q <= rx_clk;
        if (rx_clk && !rxc_q && rx_dv) begin
            if (exp_q.size() == 0) check("rx_extra", 16'h0, 16'h1);
            else check("rx_nibble", 16'(exp_q.pop_front()), {11'h0, rx_er, rxd});
        end
    end

    // Cuts a hang short.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            failures++;
            finish_test;
        end
    end

    // Registers and power modes, then detection at both speeds, then a looped-back frame.
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        tick(20);
        rd(8'h00, 16'h2000);
        rd(8'h40, 16'h0000);
        wr(8'h44, 16'hffff);
        rd(8'h44, 16'h0000);
        wr(8'h40, 16'h1000);
        tick(3);
        check("tx_clk_oe_n", 16'h1, tx_oe_n);
        check("pullup", 16'h1, tx_pu);
        check("drv_oe_n", 16'h1, drv_oe_n);
        wr(8'h40, 16'h0000);
        tick(3);
        check("drv_oe_n", 16'h0, drv_oe_n);
        check("x5", 16'h1, x5);
        wr(8'h00, 16'h2800);
        tick(3);
        check("power", 16'h0, pwr);
        rd(8'h00, 16'h2800);
        wr(8'h00, 16'h0000);
        wr(8'h40, 16'h0001);
        tick(3);
        check("x5", 16'h0, x5);
        check("rx_power", 16'h1, rx_pwr);
        manch <= 1'b1;
        pulses(6);
        tick(8);
        check("detect", 16'h0, sd);
        pulses(14);
        tick(8);
        check("threshold", 16'h1, thr);
        pre <= 1'b1;
        seen = 1'b0;
        repeat (8) begin @(posedge clk); #1 seen |= realign; end
        check("realign", 16'h1, seen);
        manch <= 1'b0;
        pre <= 1'b0;
        tick(8);
        check("detect", 16'h0, sd);
        check("threshold", 16'h0, thr);
        wr(8'h00, 16'h2000);
        tick(3);
        check("rx_power", 16'h0, rx_pwr);
        seen = 1'b0;
        repeat (12) begin @(posedge clk); #1 seen |= rx_clk; end
        check("rx_clk", 16'h0, seen);
        pulses(14);
        tick(6);
        check("rx_power", 16'h1, rx_pwr);
        check("cdr_line", 16'h1, cdr_line);
        check("adapt", 16'h1, adapt);
        tick(130);
        check("detect", 16'h1, sd);
        tick(35);
        check("detect", 16'h0, sd);
        check("cdr_line", 16'h0, cdr_line);
        wr(8'h40, 16'h0000);
        pulse_run <= 1'b1;
        tick(300);
        rd(8'h7c, 16'h0007);
        exp_q.push_back(5'h05);
        repeat (2) ppsd_mac_model_i.nib_q.push_back(4'h5);
        repeat (8) begin
            nib = 4'($random(seed));
            ppsd_mac_model_i.nib_q.push_back(nib);
            exp_q.push_back({1'b0, nib});
        end
        for (int i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge clk);
        tick(30);
        check("pending", 16'h0, 16'(exp_q.size()));
        check("rx_dv", 16'h0, rx_dv);
        finish_test;
    end
endmodule
